// >>> hdl/asg_defs.svh
// Offsets, field positions, reset values and timing counts of the
// status and general configuration register bank.
// Assumes a 25 MHz pclk; included by bare name.
`ifndef ASG_DEFS_SVH
`define ASG_DEFS_SVH
// Status and config are numbered by word index; byte address is four times it
`define ASG_IDX_STATUS 8'h00
`define ASG_IDX_CONFIG 8'h01
`define ASG_OFF_STATUS (`ASG_IDX_STATUS << 2)
`define ASG_OFF_CONFIG (`ASG_IDX_CONFIG << 2)
`define ASG_OFF_IRQ_STATUS 8'h08
`define ASG_OFF_IRQ_MASK 8'h0c
`define ASG_STATUS_RESET 8'h81
`define ASG_CONFIG_RESET 8'h00
`define ASG_ST_FIXED 7
`define ASG_ST_SEQ 6
`define ASG_ST_FUSE 2
`define ASG_ST_CRCIN 1
`define ASG_ST_BROWN 0
`define ASG_CF_REF 7
`define ASG_CF_CRC 6
`define ASG_CF_RANGE 3
`define ASG_CF_FORCE 2
`define ASG_CF_CAL 1
`define ASG_CF_SWRST 0
// Bit 0 only fires the reset pulse, so it is kept out of the store
`define ASG_CONFIG_WMASK 8'hce
`define ASG_IRQ_WIDTH 3
`define ASG_CLK_MHZ 25
`define ASG_CAL_TIME_US 20
`define ASG_CAL_CYCLES (`ASG_CAL_TIME_US * `ASG_CLK_MHZ)
`define ASG_FUSE_LOAD_CYCLES 16
`endif

// >>> hdl/asg_pkg.sv
// Types shared by the register bank and its fuse-check helper.
// Assumes asg_defs.svh for numeric constants.
package asg_pkg;
    typedef enum logic [1:0] {
        ASG_LD_IDLE = 2'b00,
        ASG_LD_BUSY = 2'b01,
        ASG_LD_DONE = 2'b10
    } asg_load_state_t;
    typedef logic [7:0] asg_byte_t;
endpackage : asg_pkg

// >>> hdl/asg_fuse_check.sv
// Power-up configuration load timer with CRC verdict capture.
// Loads itself once after power-up; assumes a restart pulse on software reset.
`timescale 1ns/1ps
`include "asg_defs.svh"
module asg_fuse_check (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic restart,
    input wire logic crc_bad,
    output logic busy,
    output logic fuse_err
);
    import asg_pkg::*;
    asg_load_state_t state_q;
    logic [4:0] cnt_q;
    logic started_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ASG_LD_IDLE;
            cnt_q <= 5'h00;
            fuse_err <= 1'b0;
            started_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                ASG_LD_IDLE: begin
                    // Load once after power-up, then only on restart
                    if (restart || !started_q) begin
                        state_q <= ASG_LD_BUSY;
                        cnt_q <= 5'h00;
                        started_q <= 1'b1;
                    end
                end
                ASG_LD_BUSY: begin
                    if (cnt_q == 5'(`ASG_FUSE_LOAD_CYCLES - 1)) begin
                        state_q <= ASG_LD_DONE;
                        fuse_err <= crc_bad;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                ASG_LD_DONE: begin
                    if (restart) begin
                        state_q <= ASG_LD_BUSY;
                        cnt_q <= 5'h00;
                    end
                end
                default: state_q <= ASG_LD_IDLE;
            endcase
        end
    end

    assign busy = (state_q == ASG_LD_BUSY);
endmodule : asg_fuse_check

// >>> hdl/asg_regs.sv
// Status and general configuration register bank on an APB slave.
// Assumes pins from the converter core arrive asynchronously; all but
// powerup_crc_bad pass a two-flop synchroniser; APB signals are on pclk.
`timescale 1ns/1ps
`include "asg_defs.svh"
module asg_regs #(
    parameter int CAL_CYCLES = `ASG_CAL_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sequence_start,
    input wire logic incoming_crc_fail,
    input wire logic brownout_pin,
    input wire logic powerup_crc_bad,
    output logic ref_enable,
    output logic crc_enable,
    output logic range_double,
    output logic force_all_analog,
    output logic calibrating,
    output logic irq
);
    import asg_pkg::*;

    localparam int CW = $clog2(CAL_CYCLES + 1);

    asg_byte_t config_q;
    logic sequencer_running_q;
    logic incoming_crc_error_q;
    logic brownout_flag_q;
    logic powerup_config_crc_error;
    logic fuse_busy;
    logic swrst_q;
    logic [CW-1:0] cal_cnt_q;
    logic [`ASG_IRQ_WIDTH-1:0] irq_stat_q;
    logic [`ASG_IRQ_WIDTH-1:0] irq_mask_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic seq_s;
    logic crc_fail_s;
    logic brown_s;
    logic crc_fail_rise;
    logic brown_rise;
    logic wr;
    logic rd;
    logic hit_status;
    logic hit_config;
    logic hit_istat;
    logic hit_imask;
    logic wr_allowed;
    logic cal_done;
    logic [`ASG_IRQ_WIDTH-1:0] irq_events;
    asg_byte_t status_view;

    // Three pins from the converter core, two flops before any use; powerup_crc_bad is not synchronised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end else if (ce) begin
            sync1_q <= {sequence_start, incoming_crc_fail, brownout_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign seq_s = sync2_q[2];
    assign crc_fail_s = sync2_q[1];
    assign brown_s = sync2_q[0];
    assign crc_fail_rise = sync2_q[1] && !sync3_q[1];
    assign brown_rise = sync2_q[0] && !sync3_q[0];

    // Zero-wait APB slave; every access completes in its access phase
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign hit_status = (paddr == `ASG_OFF_STATUS);
    assign hit_config = (paddr == `ASG_OFF_CONFIG);
    assign hit_istat = (paddr == `ASG_OFF_IRQ_STATUS);
    assign hit_imask = (paddr == `ASG_OFF_IRQ_MASK);
    assign pslverr = psel && penable &&
        !(hit_status || hit_config || hit_istat || hit_imask);
    // Blocked writes complete without error so the host is not stalled
    assign wr_allowed = !incoming_crc_error_q
        || hit_status || hit_config;

    // Software reset: pulse lasts one cycle, bit never stored visibly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swrst_q <= 1'b0;
        end else if (ce) begin
            swrst_q <= wr && hit_config
                && pwdata[`ASG_CF_SWRST];
        end
    end

    asg_fuse_check u_fuse (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .restart(swrst_q),
        .crc_bad(powerup_crc_bad),
        .busy(fuse_busy),
        .fuse_err(powerup_config_crc_error)
    );

    assign cal_done = config_q[`ASG_CF_CAL]
        && (cal_cnt_q == CW'(CAL_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_q <= `ASG_CONFIG_RESET;
        end else if (ce) begin
            if (swrst_q) begin
                config_q <= `ASG_CONFIG_RESET;
            end else if (wr && hit_config) begin
                // Reserved and reset bits never stored
                config_q <= pwdata[7:0] & `ASG_CONFIG_WMASK;
            end else if (cal_done) begin
                config_q[`ASG_CF_CAL] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_q <= '0;
        end else if (ce) begin
            if (!config_q[`ASG_CF_CAL] || cal_done) begin
                cal_cnt_q <= '0;
            end else begin
                cal_cnt_q <= cal_cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sequencer_running_q <= 1'b0;
        end else if (ce) begin
            sequencer_running_q <= swrst_q ? 1'b0 : seq_s;
        end
    end

    // Event set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            incoming_crc_error_q <= 1'b0;
        end else if (ce) begin
            if (crc_fail_s && config_q[`ASG_CF_CRC]) begin
                incoming_crc_error_q <= 1'b1;
            end else if (swrst_q) begin
                incoming_crc_error_q <= 1'b0;
            end else if (wr && hit_status && pwdata[`ASG_ST_CRCIN]) begin
                incoming_crc_error_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_flag_q <= 1'b1;
        end else if (ce) begin
            if (brown_s || swrst_q) begin
                brownout_flag_q <= 1'b1;
            end else if (wr && hit_status && pwdata[`ASG_ST_BROWN]) begin
                brownout_flag_q <= 1'b0;
            end
        end
    end

    assign irq_events = {cal_done, brown_rise,
        crc_fail_rise && config_q[`ASG_CF_CRC]};

    genvar gi;
    generate
        for (gi = 0; gi < `ASG_IRQ_WIDTH; gi++) begin : g_irq
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (ce) begin
                    if (irq_events[gi]) begin
                        irq_stat_q[gi] <= 1'b1;
                    end else if (wr && hit_istat && wr_allowed
                        && pwdata[gi]) begin
                        irq_stat_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= '0;
        end else if (ce) begin
            if (wr && hit_imask && wr_allowed) begin
                irq_mask_q <= pwdata[`ASG_IRQ_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_comb begin
        status_view = 8'h00;
        status_view[`ASG_ST_FIXED] = 1'b1;
        status_view[`ASG_ST_SEQ] = sequencer_running_q;
        status_view[`ASG_ST_FUSE] = powerup_config_crc_error;
        status_view[`ASG_ST_CRCIN] = incoming_crc_error_q;
        status_view[`ASG_ST_BROWN] = brownout_flag_q;
    end

    // Read data captured in the setup phase, valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && rd) begin
            prdata <= 32'h0000_0000;
            if (hit_status) begin
                prdata[7:0] <= status_view;
            end else if (hit_config) begin
                prdata[7:0] <= config_q;
            end else if (hit_istat) begin
                prdata[`ASG_IRQ_WIDTH-1:0] <= irq_stat_q;
            end else if (hit_imask) begin
                prdata[`ASG_IRQ_WIDTH-1:0] <= irq_mask_q;
            end
        end
    end

    assign ref_enable = config_q[`ASG_CF_REF];
    assign crc_enable = config_q[`ASG_CF_CRC];
    assign range_double = config_q[`ASG_CF_RANGE];
    assign force_all_analog = config_q[`ASG_CF_FORCE];
    assign calibrating = config_q[`ASG_CF_CAL] | fuse_busy;

    property p_fixed_one;
        @(posedge pclk) disable iff (!presetn)
        status_view[`ASG_ST_FIXED] && (status_view[5:3] == 3'h0);
    endproperty
    a_fixed_one: assert property (p_fixed_one)
        else $error("status bit 7 not one or reserved set");

    property p_seq;
        @(posedge pclk) disable iff (!presetn)
        ce && !swrst_q |=> sequencer_running_q == $past(seq_s);
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequencer status not following start");

    property p_fuse_stable;
        @(posedge pclk) disable iff (!presetn)
        !fuse_busy && !swrst_q ##1 !fuse_busy
            |-> $stable(powerup_config_crc_error);
    endproperty
    a_fuse_stable: assert property (p_fuse_stable)
        else $error("config CRC flag changed without reset");

    property p_crc_clear;
        @(posedge pclk) disable iff (!presetn)
        ce && wr && hit_status && pwdata[`ASG_ST_CRCIN] && !crc_fail_s
            |=> !incoming_crc_error_q;
    endproperty
    a_crc_clear: assert property (p_crc_clear)
        else $error("incoming CRC flag not cleared by write one");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        ce && wr && hit_imask && incoming_crc_error_q
            |=> $stable(irq_mask_q);
    endproperty
    a_block: assert property (p_block)
        else $error("write passed while CRC error set");

    property p_brown_keep;
        @(posedge pclk) disable iff (!presetn)
        ce && wr && hit_status && !pwdata[`ASG_ST_BROWN]
            && brownout_flag_q |=> brownout_flag_q;
    endproperty
    a_brown_keep: assert property (p_brown_keep)
        else $error("brown-out flag cleared by writing zero");

    property p_swrst;
        @(posedge pclk) disable iff (!presetn)
        ce && swrst_q |=> config_q == `ASG_CONFIG_RESET
            && brownout_flag_q;
    endproperty
    a_swrst: assert property (p_swrst)
        else $error("software reset did not restore defaults");

    property p_cal_end;
        @(posedge pclk) disable iff (!presetn)
        ce && cal_done && !(wr && hit_config) && !swrst_q
            |=> !config_q[`ASG_CF_CAL];
    endproperty
    a_cal_end: assert property (p_cal_end)
        else $error("calibration bit did not self-clear");

    property p_swrst_hidden;
        @(posedge pclk) disable iff (!presetn)
        !config_q[`ASG_CF_SWRST];
    endproperty
    a_swrst_hidden: assert property (p_swrst_hidden)
        else $error("software reset bit held in config");

    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data above bit 7 not zero");

    property p_istat_block;
        @(posedge pclk) disable iff (!presetn)
        ce && wr && hit_istat && incoming_crc_error_q && !(|irq_events)
            |=> $stable(irq_stat_q);
    endproperty
    a_istat_block: assert property (p_istat_block)
        else $error("interrupt status cleared while CRC error set");

    property p_brown_set;
        @(posedge pclk) disable iff (!presetn)
        ce && (brown_s || swrst_q) |=> brownout_flag_q;
    endproperty
    a_brown_set: assert property (p_brown_set)
        else $error("brown-out flag not set");

    property p_crc_gate;
        @(posedge pclk) disable iff (!presetn)
        ce && !config_q[`ASG_CF_CRC] && !incoming_crc_error_q
            |=> !incoming_crc_error_q;
    endproperty
    a_crc_gate: assert property (p_crc_gate)
        else $error("incoming CRC flag set while CRC disabled");

    c_swrst: cover property (@(posedge pclk) disable iff (!presetn)
        swrst_q);
    c_cal: cover property (@(posedge pclk) disable iff (!presetn)
        cal_done);
    c_crc_err: cover property (@(posedge pclk) disable iff (!presetn)
        incoming_crc_error_q && wr && hit_status);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn)
        irq);
endmodule : asg_regs

// >>> verif/asg_core_model.sv
// Model of the converter core beside the register bank.
// Assumes the bench calls its tasks from its pclk-driven sequence.
`timescale 1ns/1ps
module asg_core_model (
    input wire logic pclk,
    output logic sequence_start,
    output logic incoming_crc_fail,
    output logic brownout_pin,
    output logic powerup_crc_bad
);
    initial begin
        sequence_start = 1'b0;
        incoming_crc_fail = 1'b0;
        brownout_pin = 1'b0;
        powerup_crc_bad = 1'b0;
    end
    // The sequence_start pin, not a host field, is what sets the sequencer status
    task automatic set_seq(input logic v);
        @(posedge pclk);
        sequence_start <= v;
    endtask : set_seq
    task automatic set_fuse(input logic v);
        @(posedge pclk);
        powerup_crc_bad <= v;
    endtask : set_fuse
    // Faults last two cycles so the two-flop synchroniser sees them
    task automatic pulse_crc;
        @(posedge pclk);
        incoming_crc_fail <= 1'b1;
        repeat (2) @(posedge pclk);
        incoming_crc_fail <= 1'b0;
    endtask : pulse_crc
    task automatic pulse_brown;
        @(posedge pclk);
        brownout_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        brownout_pin <= 1'b0;
    endtask : pulse_brown
endmodule : asg_core_model

// >>> verif/tb_top.sv
// Self-checking bench for the status and config register bank.
// Assumes asg_regs and asg_core_model are compiled before it.
`timescale 1ns/1ps
`include "asg_defs.svh"
module tb_top;
    localparam int CAL = 8;
    localparam logic [7:0] ST = `ASG_OFF_STATUS;
    localparam logic [7:0] CF = `ASG_OFF_CONFIG;
    localparam logic [7:0] IS = `ASG_OFF_IRQ_STATUS;
    localparam logic [7:0] IM = `ASG_OFF_IRQ_MASK;
    localparam logic [7:0] CFG [4] = '{8'h80, 8'h40, 8'h08, 8'h04};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic seq_in, crc_in, brown_in, fuse_in;
    logic ref_en, crc_en, rng, force_an, cal, irq;
    int miscompares, tests_run, cycles;

    asg_regs #(.CAL_CYCLES(CAL)) asg_regs_i (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sequence_start(seq_in),
        .incoming_crc_fail(crc_in), .brownout_pin(brown_in),
        .powerup_crc_bad(fuse_in), .ref_enable(ref_en),
        .crc_enable(crc_en), .range_double(rng),
        .force_all_analog(force_an), .calibrating(cal), .irq(irq)
    );
    asg_core_model asg_core_model_i (
        .pclk(pclk), .sequence_start(seq_in),
        .incoming_crc_fail(crc_in), .brownout_pin(brown_in),
        .powerup_crc_bad(fuse_in)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Holds the request until pready is seen high; no latency assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(12);
        presetn <= 1'b1;
        cyc(24);
        rdchk(ST, 32'h81);
        rdchk(CF, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(ST, 32'h0);
        rdchk(ST, 32'h81);
        wr(ST, 32'h1);
        rdchk(ST, 32'h80);
        asg_core_model_i.pulse_brown();
        cyc(5);
        rdchk(ST, 32'h81);
        wr(ST, 32'h1);
        asg_core_model_i.set_seq(1'b1);
        cyc(5);
        rdchk(ST, 32'hc0);
        asg_core_model_i.set_seq(1'b0);
        cyc(5);
        rdchk(ST, 32'h80);
        for (int i = 0; i < 4; i++) begin
            wr(CF, {24'h0, CFG[i]});
            cyc(1);
            chk({28'h0, ref_en, crc_en, rng, force_an}, 32'h8 >> i);
        end
        wr(CF, 32'hfc);
        rdchk(CF, 32'hcc);
        wr(CF, 32'h2);
        // The write lands at the task's last edge; look one edge later
        cyc(1);
        chk({31'h0, cal}, 32'h1);
        rdchk(CF, 32'h2);
        cyc(CAL + 4);
        rdchk(CF, 32'h0);
        asg_core_model_i.pulse_crc();
        cyc(5);
        rdchk(ST, 32'h80);
        wr(IS, 32'h7);
        wr(IM, 32'h0);
        wr(CF, 32'h40);
        asg_core_model_i.pulse_crc();
        cyc(5);
        rdchk(ST, 32'h82);
        chk({31'h0, irq}, 32'h0);
        wr(IM, 32'h1);
        rdchk(IM, 32'h0);
        wr(IS, 32'h1);
        rdchk(IS, 32'h1);
        wr(CF, 32'h48);
        rdchk(CF, 32'h48);
        wr(ST, 32'h2);
        rdchk(ST, 32'h80);
        wr(IM, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(IS, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        asg_core_model_i.set_fuse(1'b1);
        wr(ST, 32'h4);
        cyc(3);
        rdchk(ST, 32'h80);
        wr(CF, 32'h1);
        cyc(24);
        rdchk(ST, 32'h85);
        rdchk(CF, 32'h0);
        asg_core_model_i.set_fuse(1'b0);
        wr(CF, 32'h1);
        cyc(24);
        rdchk(ST, 32'h81);
        summarize();
    end
endmodule : tb_top
